//--- tvir_pkg.sv
// tvir_pkg: constants, states and carrier types for the telemetry readback block.
// assumes the adc delivers 10-bit codes at 2 mV per step on the block's own clock.
package tvir_pkg;

	////////////////////////////////////////////////////////////////////////////
	// command codes and word layout
	localparam logic [7:0]  TVIR_CMD_OUTPUT_VOLTAGE = 8'h89;
	localparam logic [7:0]  TVIR_CMD_INPUT_CURRENT  = 8'h8C;
	localparam int          TVIR_CODE_WIDTH         = 10;
	localparam int          TVIR_WORD_WIDTH         = 16;
	localparam int          TVIR_CODE_LSB           = 0;
	localparam int          TVIR_UNUSED_LSB         = 10;
	localparam int          TVIR_UNUSED_MSB         = 15;
	localparam logic [5:0]  TVIR_UNUSED_FILL        = 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// reset values and fills
	localparam logic [9:0]  TVIR_CODE_RESET         = 10'h000;
	localparam logic [7:0]  TVIR_CMD_RESET          = 8'h00;
	localparam logic [15:0] TVIR_NO_DATA_WORD       = 16'hFFFF;
	localparam logic [7:0]  TVIR_NO_DATA_BYTE       = 8'hFF;
	localparam logic [15:0] TVIR_WORD_RESET         = 16'h0000;
	localparam logic [7:0]  TVIR_SHIFT_RESET        = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// serial framing counts
	localparam logic [3:0]  TVIR_BITS_PER_BYTE      = 4'h8;
	localparam logic [3:0]  TVIR_BIT_CNT_RESET      = 4'h0;
	localparam logic [3:0]  TVIR_FIRST_BIT_SENT     = 4'h1;
	localparam logic [1:0]  TVIR_BYTE_LOW           = 2'h0;
	localparam logic [1:0]  TVIR_BYTE_HIGH          = 2'h1;
	localparam logic [1:0]  TVIR_BYTE_IDX_RESET     = 2'h0;
	localparam int          TVIR_SYNC_STAGES        = 3;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic       valid;
		logic [9:0] code;
	} tvir_sample_s;

	typedef enum logic [2:0] {
		TVIR_ST_IDLE  = 3'b000,
		TVIR_ST_ADDR  = 3'b001,
		TVIR_ST_CMD   = 3'b010,
		TVIR_ST_WR    = 3'b011,
		TVIR_ST_ACK   = 3'b100,
		TVIR_ST_RD    = 3'b101,
		TVIR_ST_RACK  = 3'b110,
		TVIR_ST_RLOAD = 3'b111
	} tvir_state_e;

endpackage : tvir_pkg

//--- tvir_pin_sync.sv
// tvir_pin_sync: three-stage synchroniser with an agreement filter for one pin.
// assumes the pin is asynchronous to i_clk; output moves once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module tvir_pin_sync
	import tvir_pkg::*;
#(
	parameter logic INIT = 1'b1
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// pin and filtered level
	input  wire logic i_pin,
	output var  logic o_level
);

	logic stage1_reg;
	logic stage2_reg;
	logic stage3_reg;
	logic level_reg;
	logic agree;

	// stage one feeds stage two only
	assign agree   = (stage2_reg == stage3_reg);
	assign o_level = level_reg;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			stage1_reg <= INIT;
			stage2_reg <= INIT;
			stage3_reg <= INIT;
			level_reg  <= INIT;
		end else begin
			stage1_reg <= i_pin;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			if (agree) begin
				level_reg <= stage3_reg;
			end
		end
	end

endmodule : tvir_pin_sync
`default_nettype wire

//--- tvir_readback.sv
// tvir_readback: output-voltage and input-current readback over a two-wire bus slave.
// assumes scl/sda are external open-drain pins and adc samples arrive on i_clk.
//
// Notes on behaviour
// - command 89h reads back a two-byte word of the feedback pin voltage.
// - output-voltage word: bits 9:0 unsigned code at 2 mV, bits 15:10 unused.
// - output-voltage field spans 0 V to 2.046 V; host scales by divider.
// - command 8Ch reads back two bytes of the current monitor pin voltage.
// - input-current word: bits 9:0 unsigned code at 2 mV, bits 15:10 unused.
// - both readings use the unsigned word format, only ten code bits used.
`timescale 1ns/1ps
`default_nettype none
module tvir_readback
	import tvir_pkg::*;
#(
	// bus address, arbitrary value
	parameter logic [6:0] DEV_ADDR = 7'h40
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// adc samples
	input  wire tvir_sample_s i_feedback_pin,
	input  wire tvir_sample_s i_current_monitor_pin,
	// serial bus pins
	input  wire logic         i_scl,
	input  wire logic         i_sda,
	output var  logic         o_sda,
	output var  logic         o_sda_oe
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic scl_lvl;
	logic sda_lvl;

	tvir_pin_sync #(.INIT(1'b1)) u_scl_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_pin   (i_scl),
		.o_level (scl_lvl)
	);

	tvir_pin_sync #(.INIT(1'b1)) u_sda_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_pin   (i_sda),
		.o_level (sda_lvl)
	);

	////////////////////////////////////////////////////////////////////////////
	// state
	tvir_state_e state_reg,    state_next;
	tvir_state_e after_reg,    after_next;
	logic [3:0]  bit_cnt_reg,  bit_cnt_next;
	logic [7:0]  shift_reg,    shift_next;
	logic [7:0]  cmd_reg,      cmd_next;
	logic [15:0] tx_word_reg,  tx_word_next;
	logic [1:0]  byte_idx_reg, byte_idx_next;
	logic        sda_oe_reg,   sda_oe_next;
	logic        sda_o_reg;
	logic [9:0]  fb_code_reg;
	logic [9:0]  current_monitor_pin_code_reg;
	logic        scl_prev_reg;
	logic        sda_prev_reg;

	////////////////////////////////////////////////////////////////////////////
	// bus conditions
	wire scl_rise   = scl_lvl & ~scl_prev_reg;
	wire scl_fall   = ~scl_lvl & scl_prev_reg;
	wire start_cond = scl_lvl & scl_prev_reg & sda_prev_reg & ~sda_lvl;
	wire stop_cond  = scl_lvl & scl_prev_reg & ~sda_prev_reg & sda_lvl;
	wire byte_full  = (bit_cnt_reg == TVIR_BITS_PER_BYTE);
	wire addr_match = (shift_reg[7:1] == DEV_ADDR);
	wire addr_read  = shift_reg[0];

	////////////////////////////////////////////////////////////////////////////
	// reading words; unused high bits fixed, code is 10 bits so 2.046 V tops out
	wire [15:0] vout_word = {TVIR_UNUSED_FILL, fb_code_reg};
	wire [15:0] iin_word  = {TVIR_UNUSED_FILL, current_monitor_pin_code_reg};
	wire        sel_vout  = (cmd_reg == TVIR_CMD_OUTPUT_VOLTAGE);
	wire        sel_iin   = (cmd_reg == TVIR_CMD_INPUT_CURRENT);
	wire [15:0] sel_word  = sel_vout ? vout_word :
	                        sel_iin  ? iin_word  :
	                                   TVIR_NO_DATA_WORD;
	// low byte goes out first, then the high byte; the two after read as no-data, then the 2-bit index wraps to the low byte
	wire [7:0]  tx_byte   = (byte_idx_reg == TVIR_BYTE_LOW)  ? tx_word_reg[7:0]  :
	                        (byte_idx_reg == TVIR_BYTE_HIGH) ? tx_word_reg[15:8] :
	                                                           TVIR_NO_DATA_BYTE;

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		state_next    = state_reg;
		after_next    = after_reg;
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		cmd_next      = cmd_reg;
		tx_word_next  = tx_word_reg;
		byte_idx_next = byte_idx_reg;
		sda_oe_next   = sda_oe_reg;
		if (stop_cond) begin
			state_next  = TVIR_ST_IDLE;
			sda_oe_next = 1'b0;
		end else if (start_cond) begin
			// repeated start keeps cmd_reg for the read phase
			state_next   = TVIR_ST_ADDR;
			bit_cnt_next = TVIR_BIT_CNT_RESET;
			sda_oe_next  = 1'b0;
		end else begin
			case (state_reg)
				TVIR_ST_ADDR, TVIR_ST_CMD, TVIR_ST_WR: begin
					if (scl_rise && !byte_full) begin
						shift_next   = {shift_reg[6:0], sda_lvl};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end else if (scl_fall && byte_full) begin
						bit_cnt_next = TVIR_BIT_CNT_RESET;
						sda_oe_next  = 1'b1;
						state_next   = TVIR_ST_ACK;
						after_next   = TVIR_ST_WR;
						if (state_reg == TVIR_ST_ADDR) begin
							if (!addr_match) begin
								sda_oe_next = 1'b0;
								state_next  = TVIR_ST_IDLE;
							end else if (addr_read) begin
								// snapshot keeps both bytes of one sample
								after_next    = TVIR_ST_RD;
								tx_word_next  = sel_word;
								byte_idx_next = TVIR_BYTE_IDX_RESET;
							end else begin
								after_next = TVIR_ST_CMD;
							end
						end else if (state_reg == TVIR_ST_CMD) begin
							cmd_next = shift_reg;
						end
						// data bytes in TVIR_ST_WR are acked and dropped
					end
				end
				TVIR_ST_ACK: begin
					if (scl_fall) begin
						state_next  = after_reg;
						sda_oe_next = 1'b0;
						if (after_reg == TVIR_ST_RD) begin
							shift_next   = tx_byte;
							sda_oe_next  = ~tx_byte[7];
							bit_cnt_next = TVIR_FIRST_BIT_SENT;
						end
					end
				end
				TVIR_ST_RD: begin
					if (scl_fall) begin
						if (byte_full) begin
							sda_oe_next = 1'b0;
							state_next  = TVIR_ST_RACK;
						end else begin
							sda_oe_next  = ~shift_reg[6];
							shift_next   = {shift_reg[6:0], 1'b0};
							bit_cnt_next = bit_cnt_reg + 4'h1;
						end
					end
				end
				TVIR_ST_RACK: begin
					if (scl_rise) begin
						if (sda_lvl) begin
							state_next = TVIR_ST_IDLE;
						end else begin
							byte_idx_next = byte_idx_reg + 2'h1;
							state_next    = TVIR_ST_RLOAD;
						end
					end
				end
				TVIR_ST_RLOAD: begin
					if (scl_fall) begin
						shift_next   = tx_byte;
						sda_oe_next  = ~tx_byte[7];
						bit_cnt_next = TVIR_FIRST_BIT_SENT;
						state_next   = TVIR_ST_RD;
					end
				end
				default: begin
					state_next  = TVIR_ST_IDLE;
					sda_oe_next = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg    <= TVIR_ST_IDLE;
			after_reg    <= TVIR_ST_IDLE;
			bit_cnt_reg  <= TVIR_BIT_CNT_RESET;
			shift_reg    <= TVIR_SHIFT_RESET;
			cmd_reg      <= TVIR_CMD_RESET;
			tx_word_reg  <= TVIR_WORD_RESET;
			byte_idx_reg <= TVIR_BYTE_IDX_RESET;
			sda_oe_reg   <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			state_reg    <= state_next;
			after_reg    <= after_next;
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			cmd_reg      <= cmd_next;
			tx_word_reg  <= tx_word_next;
			byte_idx_reg <= byte_idx_next;
			sda_oe_reg   <= sda_oe_next;
			scl_prev_reg <= scl_lvl;
			sda_prev_reg <= sda_lvl;
		end
	end

	// latest adc codes; the host never writes these
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			fb_code_reg   <= TVIR_CODE_RESET;
			current_monitor_pin_code_reg <= TVIR_CODE_RESET;
			sda_o_reg     <= 1'b0;
		end else begin
			if (i_feedback_pin.valid) begin
				fb_code_reg <= i_feedback_pin.code;
			end
			if (i_current_monitor_pin.valid) begin
				current_monitor_pin_code_reg <= i_current_monitor_pin.code;
			end
			// open drain: only ever pulls low
			sda_o_reg <= 1'b0;
		end
	end

	assign o_sda    = sda_o_reg;
	assign o_sda_oe = sda_oe_reg;

endmodule : tvir_readback
`default_nettype wire

//--- tvir_readback_monitor.sv
// tvir_readback_monitor: pin-level checks on the readback bus slave.
// assumes one clock domain and the sda wire as seen by the slave.
`timescale 1ns/1ps
`default_nettype none
module tvir_readback_monitor
	import tvir_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// bus pins
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic o_sda,
	input  wire logic o_sda_oe
);
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire logic bus_start = !i_sda && i_scl;
	wire logic bus_stop  = i_sda && i_scl;
	AST_OD_LOW: assert property (o_sda == 1'b0)
		else $error("sda data not low");
	AST_RST_REL: assert property (disable iff (1'b0) i_reset |-> !o_sda_oe)
		else $error("sda driven in reset");
	// a change while scl is high would look like start or stop
	AST_CHG_LOW: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
		else $error("sda moved with scl high");
	AST_DRV_HOLD: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8])
		else $error("driven bit too short");
	AST_REL_HOLD: assert property ($fell(o_sda_oe) |-> !o_sda_oe[*8])
		else $error("released bit too short");
	AST_START_REL: assert property ($fell(i_sda) && bus_start && $past(i_scl)
		|-> !o_sda_oe[*4])
		else $error("sda driven at start");
	AST_STOP_REL: assert property ($rose(i_sda) && bus_stop && $past(i_scl)
		|=> !o_sda_oe[*8])
		else $error("sda driven after stop");
endmodule : tvir_readback_monitor
bind tvir_readback tvir_readback_monitor tvir_readback_monitor_i (.i_clk(i_clk),
	.i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe));
`default_nettype wire

//--- tvir_host.sv
// tvir_host: bus host model, 16 clocks a bit, scl stands high between frames.
// assumes the sda wire is resolved outside with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tvir_host
	import tvir_pkg::*;
(
	// clock
	input  wire logic i_clk,
	// bus pins
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda_oe
);
	////////////////////////////////////////////////////////////
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// host-side scaling of a monitor-pin code to input current, in units of 10 mA
	localparam real MON_OHM = 57600.0;
	localparam real SET_OHM = 483.1;
	localparam real SEN_OHM = 0.001;
	function automatic logic [15:0] iin_centiamps(input logic [9:0] code);
		real amps;
		amps = (code * 0.002 / MON_OHM - 17.0e-6) * 8.0 * SET_OHM / SEN_OHM;
		return 16'($rtoi(amps * 100.0));
	endfunction : iin_centiamps
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	// sda moves mid-low; sampled late in the high half
	task automatic clk_bit(input logic pull, output logic got);
		o_scl <= 1'b0;
		tick(4);
		o_sda_oe <= pull;
		tick(4);
		o_scl <= 1'b1;
		tick(7);
		@(negedge i_clk) got = i_sda;
		tick(1);
	endtask : clk_bit
	task automatic start;
		o_sda_oe <= 1'b1;
		tick(8);
	endtask : start
	task automatic stop;
		logic d;
		clk_bit(1'b1, d);
		o_sda_oe <= 1'b0;
		tick(8);
	endtask : stop
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic d;
		for (int i = 7; i >= 0; i--)
			clk_bit(!b[i], d);
		clk_bit(1'b0, d);
		ack = !d;
	endtask : put_byte
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic d;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b0, b[i]);
		clk_bit(!last, d);
	endtask : get_byte
	task automatic read_word(input logic [6:0] a, input logic use_cmd,
		input logic [7:0] c, output logic [15:0] w, output logic ack);
		logic a0, a1, a2;
		a0 = 1'b1;
		a1 = 1'b1;
		if (use_cmd) begin
			start();
			put_byte({a, 1'b0}, a0);
			put_byte(c, a1);
			clk_bit(1'b0, a2);
		end
		start();
		put_byte({a, 1'b1}, a2);
		get_byte(1'b0, w[7:0]);
		get_byte(1'b1, w[15:8]);
		stop();
		ack = a0 & a1 & a2;
	endtask : read_word
	task automatic write_word(input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] d, output logic ack);
		logic k0, k1, k2, k3;
		start();
		put_byte({a, 1'b0}, k0);
		put_byte(c, k1);
		put_byte(d[7:0], k2);
		put_byte(d[15:8], k3);
		stop();
		ack = k0 & k1 & k2 & k3;
	endtask : write_word
endmodule : tvir_host
`default_nettype wire

//--- test_tvir_readback.sv
// test_tvir_readback: register reads and writes through the bus host model.
// assumes the slave reuses its last command and fills unknowns with ones.
`timescale 1ns/1ps
`default_nettype none
module test_tvir_readback;
	import tvir_pkg::*;
	localparam logic [6:0] ADDR = 7'h40;
	logic         i_clk;
	logic         i_reset;
	logic         scl;
	logic         host_oe;
	logic         dut_sda;
	logic         dut_oe;
	tvir_sample_s fb;
	tvir_sample_s im;
	logic [15:0]  rd_word;
	logic         rd_ack;
	int           miscompares;
	int           compares;
	// open-drain wire with pull-up
	wire logic    sda = !(host_oe | dut_oe);
	tvir_readback #(.DEV_ADDR(ADDR)) tvir_readback_i (.i_clk(i_clk), .i_reset(i_reset),
		.i_feedback_pin(fb), .i_current_monitor_pin(im), .i_scl(scl), .i_sda(sda),
		.o_sda(dut_sda), .o_sda_oe(dut_oe));
	tvir_host tvir_host_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
	////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task automatic cmp_ack(input logic got, input logic exp);
		cmp_word({15'h0000, got}, {15'h0000, exp});
	endtask : cmp_ack
	task automatic set_adc(input logic [9:0] v, input logic [9:0] c);
		@(posedge i_clk);
		fb <= '{1'b1, v};
		im <= '{1'b1, c};
		@(posedge i_clk);
		fb.valid <= 1'b0;
		im.valid <= 1'b0;
	endtask : set_adc
	task automatic rd(input logic [6:0] a, input logic u, input logic [7:0] c,
		input logic [15:0] exp, input logic exp_ack);
		logic [15:0] w;
		logic        k;
		tvir_host_i.read_word(a, u, c, w, k);
		cmp_word(w, exp);
		cmp_ack(k, exp_ack);
	endtask : rd
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		logic k;
		tvir_host_i.write_word(ADDR, c, d, k);
		cmp_ack(k, 1'b1);
	endtask : wr
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#300_000;
		miscompares++;
		stop_test();
	end
	initial begin
		i_reset = 1'b1;
		fb = '0;
		im = '0;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		repeat (8) @(posedge i_clk);
		rd(ADDR, 1'b1, TVIR_CMD_OUTPUT_VOLTAGE, 16'h0000, 1'b1);
		set_adc(10'h3FF, 10'h155);
		rd(ADDR, 1'b1, TVIR_CMD_OUTPUT_VOLTAGE, 16'h03FF, 1'b1);
		rd(ADDR, 1'b1, TVIR_CMD_INPUT_CURRENT, 16'h0155, 1'b1);
		rd(ADDR, 1'b0, 8'h00, 16'h0155, 1'b1);
		wr(TVIR_CMD_OUTPUT_VOLTAGE, 16'hFFFF);
		rd(ADDR, 1'b0, 8'h00, 16'h03FF, 1'b1);
		rd(ADDR, 1'b1, 8'h8D, 16'hFFFF, 1'b1);
		rd(7'h41, 1'b1, TVIR_CMD_OUTPUT_VOLTAGE, 16'hFFFF, 1'b0);
		set_adc(10'h2AA, 10'h000);
		rd(ADDR, 1'b1, TVIR_CMD_OUTPUT_VOLTAGE, 16'h02AA, 1'b1);
		rd(ADDR, 1'b1, TVIR_CMD_INPUT_CURRENT, 16'h0000, 1'b1);
		// code 800 on the example board is 41.65 A
		set_adc(10'h2AA, 10'h320);
		tvir_host_i.read_word(ADDR, 1'b1, TVIR_CMD_INPUT_CURRENT, rd_word, rd_ack);
		cmp_ack(rd_ack, 1'b1);
		cmp_word(rd_word, 16'h0320);
		cmp_word(tvir_host_i.iin_centiamps(rd_word[9:0]), 16'h1045);
		stop_test();
	end
endmodule : test_tvir_readback
`default_nettype wire
